// [include/css_pkg.sv]
package css_pkg;

  // clock and modulator timing
  localparam int CSS_CLK_KHZ = 40000;
  localparam int CSS_SAMPLE_KHZ = 250;
  localparam int CSS_TICK_CYCLES = CSS_CLK_KHZ / CSS_SAMPLE_KHZ;
  localparam logic [7:0] CSS_TICK_LAST = 8'(CSS_TICK_CYCLES - 1);

  // per-stage output interval in ns, as produced by 3 x rate samples at 4 us
  localparam int CSS_STAGE_NS_256 = 3072000;
  localparam int CSS_STAGE_NS_128 = 1536000;
  localparam int CSS_STAGE_NS_64 = 768000;

  // decimation
  localparam logic [1:0] CSS_DEC_256 = 2'h0;
  localparam logic [1:0] CSS_DEC_128 = 2'h1;
  localparam logic [3:0] CSS_SHIFT_256 = 4'h8;
  localparam logic [3:0] CSS_SHIFT_128 = 4'h7;
  localparam logic [3:0] CSS_SHIFT_64 = 4'h6;
  localparam logic [9:0] CSS_AVG_MULT = 10'h003;
  localparam logic [25:0] CSS_AVG_DIV = 26'h0000003;

  // sequencer
  localparam int CSS_STAGES = 8;
  localparam logic [3:0] CSS_MAX_STAGE = 4'h7;

  // power control word fields
  localparam int CSS_PM_LSB = 0;
  localparam int CSS_LAST_LSB = 4;
  localparam int CSS_DEC_LSB = 8;
  localparam logic [1:0] CSS_PM_FULL = 2'h0;
  localparam logic [1:0] CSS_PM_LOW = 2'h2;
  localparam logic [9:0] CSS_PWR_MASK = 10'h3ff;

  // stage configuration word fields
  localparam int CSS_CFG_POS_LSB = 0;
  localparam int CSS_CFG_POS_SWAP = 6;
  localparam int CSS_CFG_NEG_LSB = 8;
  localparam int CSS_CFG_NEG_SWAP = 14;
  localparam int CSS_CFG_MUX_LSB = 16;

  // register indices; byte address is four times the index
  localparam logic [7:0] CSS_IDX_PWR = 8'h00;
  localparam logic [7:0] CSS_IDX_CALEN = 8'h01;
  localparam logic [7:0] CSS_IDX_STATUS = 8'h02;
  localparam logic [7:0] CSS_IDX_ACTIVE = 8'h03;
  localparam logic [7:0] CSS_IDX_THRESH = 8'h04;
  localparam logic [7:0] CSS_IDX_DIFF = 8'h05;
  localparam logic [7:0] CSS_IDX_RES0 = 8'h0b;
  localparam logic [7:0] CSS_IDX_RES7 = 8'h12;
  localparam logic [7:0] CSS_IDX_CFG0 = 8'h20;
  localparam logic [7:0] CSS_IDX_CFG7 = 8'h27;

  // reset values
  localparam logic [15:0] CSS_THR_LO_RST = 16'h7000;
  localparam logic [15:0] CSS_THR_HI_RST = 16'h9000;

  // bus answers
  localparam logic [1:0] CSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSS_RESP_SLVERR = 2'h2;

  function automatic logic [3:0] css_dec_shift(input logic [1:0] dec);
    if (dec == CSS_DEC_256) begin
      return CSS_SHIFT_256;
    end else if (dec == CSS_DEC_128) begin
      return CSS_SHIFT_128;
    end
    return CSS_SHIFT_64;
  endfunction

endpackage

// [include/css_avg_if.sv]
interface css_avg_if;
  logic clear;
  logic tick;
  logic [15:0] sample;
  logic [3:0] shift;
  logic done;
  logic [15:0] result;

  modport seq (output clear, output tick, output sample, output shift,
               input done, input result);
  modport avg (input clear, input tick, input sample, input shift,
               output done, output result);
endinterface

// [verilog/css_averager.sv]
module css_averager (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // sequencer side
  css_avg_if.avg av
);
  import css_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic [25:0] sum;
    logic done;
    logic [15:0] result;
  } css_avg_state_t;

  css_avg_state_t s;
  css_avg_state_t next_s;

  always_comb begin
    logic [9:0] last_cnt;
    logic [25:0] total;
    logic [25:0] quot;
    last_cnt = 10'((CSS_AVG_MULT << av.shift) - 10'h001);
    total = s.sum + {10'h000, av.sample};
    quot = total / CSS_AVG_DIV;
    next_s = s;
    next_s.done = 1'b0;
    if (av.clear) begin
      next_s.cnt = '0;
      next_s.sum = '0;
    end else if (av.tick) begin
      if (s.cnt == last_cnt) begin
        // 3 x decimation samples averaged into one 16-bit unsigned code
        next_s.done = 1'b1;
        next_s.result = 16'(quot >> av.shift);
        next_s.cnt = '0;
        next_s.sum = '0;
      end else begin
        next_s.sum = total;
        next_s.cnt = 10'(s.cnt + 10'h001);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign av.done = s.done;
  assign av.result = s.result;
endmodule

// [verilog/css_sequencer.sv]
// Functional notes
// - modulator sampled at fixed 250 kHz
// - bits 9:8 pick decimation 256/128/64
// - stage result every 3.072/1.536/0.768 ms
// - average three times decimation rate samples
// - sequence starts stage 0, ends last index
// - at most eight stages, own mux each
// - sequence time is stages times stage interval
// - six-bit positive/negative offsets, either input
// - differential pair pressed together reports neither
// - each stage result is 16-bit unsigned
// - results stored at indices 0x00b to 0x012
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
module css_sequencer (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // modulator front end
  input wire logic [15:0] mod_sample_in,
  output logic sample_strobe_out,
  output logic [2:0] stage_out,
  output logic [15:0] sensor_input_pin_setup_out,
  output logic [5:0] positive_offset_code_out,
  output logic [5:0] negative_offset_code_out,
  output logic pos_offset_to_neg_input_out,
  output logic neg_offset_to_pos_input_out,
  output logic calib_enable_out,
  output logic sequence_done_out,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import css_pkg::*;

  typedef struct packed {
    // bus slave
    logic awready;
    logic wready;
    logic aw_held;
    logic [7:0] aw_idx;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // software registers
    logic [9:0] power_control_word;
    logic [7:0] per_stage_calib_enable;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [7:0] diff_en;
    logic [CSS_STAGES-1:0][31:0] stage_cfg;
    logic [CSS_STAGES-1:0][15:0] stage_result_word;
    logic [7:0] active_pos;
    logic [7:0] active_neg;
    // sequencer
    logic [7:0] tick_cnt;
    logic [15:0] samp_s1;
    logic [15:0] samp_s2;
    logic strobe;
    logic avg_clear;
    logic [2:0] stage;
    logic [15:0] seq_cnt;
    logic seq_done;
    logic [31:0] cur_cfg;
    logic cur_cal;
  } css_seq_state_t;

  css_seq_state_t s;
  css_seq_state_t next_s;

  css_avg_if avg_bus ();

  css_averager u_averager (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .av(avg_bus.avg)
  );

  assign avg_bus.clear = s.avg_clear;
  assign avg_bus.tick = s.strobe;
  assign avg_bus.sample = s.samp_s2;
  assign avg_bus.shift = css_dec_shift(s.power_control_word[CSS_DEC_LSB +: 2]);

  function automatic logic [31:0] css_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic css_mapped(input logic [7:0] idx);
    return (idx <= CSS_IDX_DIFF) ||
           (idx >= CSS_IDX_RES0 && idx <= CSS_IDX_RES7) ||
           (idx >= CSS_IDX_CFG0 && idx <= CSS_IDX_CFG7);
  endfunction

  always_comb begin
    logic [3:0] last_stage;
    logic [2:0] nstage;
    logic [31:0] merged;
    logic [7:0] ridx;
    logic running;
    logic above;
    logic below;
    logic restart;
    last_stage = '0;
    nstage = '0;
    merged = '0;
    ridx = '0;
    running = 1'b0;
    above = 1'b0;
    below = 1'b0;
    restart = 1'b0;
    next_s = s;
    next_s.seq_done = 1'b0;

    // ---------------- write channel: address and data in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = s_axi_awaddr[9:2];
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
      next_s.wready = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = css_mapped(s.aw_idx) ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
      unique case (s.aw_idx)
        CSS_IDX_PWR: begin
          merged = css_merge({22'h000000, s.power_control_word}, s.wdata,
                             s.wstrb);
          next_s.power_control_word = merged[9:0] & CSS_PWR_MASK;
          // a new rate mid-stage could leave the count past its target
          restart = merged[CSS_DEC_LSB +: 2] !=
                    s.power_control_word[CSS_DEC_LSB +: 2];
        end
        CSS_IDX_CALEN: begin
          merged = css_merge({24'h000000, s.per_stage_calib_enable},
                             s.wdata, s.wstrb);
          next_s.per_stage_calib_enable = merged[7:0];
        end
        CSS_IDX_THRESH: begin
          merged = css_merge({s.thr_hi, s.thr_lo}, s.wdata, s.wstrb);
          next_s.thr_lo = merged[15:0];
          next_s.thr_hi = merged[31:16];
        end
        CSS_IDX_DIFF: begin
          merged = css_merge({24'h000000, s.diff_en}, s.wdata, s.wstrb);
          next_s.diff_en = merged[7:0];
        end
        default: begin
          if (s.aw_idx >= CSS_IDX_CFG0 && s.aw_idx <= CSS_IDX_CFG7) begin
            next_s.stage_cfg[s.aw_idx[2:0]] = css_merge(
                s.stage_cfg[s.aw_idx[2:0]], s.wdata, s.wstrb);
          end
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // ---------------- read channel
    if (s_axi_arvalid && s.arready) begin
      ridx = s_axi_araddr[9:2];
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = css_mapped(ridx) ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
      next_s.rdata = '0;
      unique case (ridx)
        CSS_IDX_PWR: next_s.rdata = {22'h000000, s.power_control_word};
        CSS_IDX_CALEN: next_s.rdata = {24'h000000, s.per_stage_calib_enable};
        CSS_IDX_STATUS: next_s.rdata = {s.seq_cnt, 12'h000, 1'b0, s.stage};
        CSS_IDX_ACTIVE: next_s.rdata = {16'h0000, s.active_neg, s.active_pos};
        CSS_IDX_THRESH: next_s.rdata = {s.thr_hi, s.thr_lo};
        CSS_IDX_DIFF: next_s.rdata = {24'h000000, s.diff_en};
        default: begin
          if (ridx >= CSS_IDX_RES0 && ridx <= CSS_IDX_RES7) begin
            next_s.rdata = {16'h0000,
                s.stage_result_word[3'(ridx - CSS_IDX_RES0)]};
          end else if (ridx >= CSS_IDX_CFG0 && ridx <= CSS_IDX_CFG7) begin
            next_s.rdata = s.stage_cfg[ridx[2:0]];
          end
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // ---------------- modulator sample clock, fixed 250 kHz
    next_s.samp_s1 = mod_sample_in;
    next_s.samp_s2 = s.samp_s1;
    next_s.strobe = 1'b0;
    if (s.tick_cnt == CSS_TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.strobe = 1'b1;
    end else begin
      next_s.tick_cnt = 8'(s.tick_cnt + 8'h01);
    end

    // ---------------- conversion sequencer
    // shutdown codes 01 and 11 hold the sequence parked at stage 0
    running = (s.power_control_word[CSS_PM_LSB +: 2] == CSS_PM_FULL) ||
              (s.power_control_word[CSS_PM_LSB +: 2] == CSS_PM_LOW);
    last_stage = s.power_control_word[CSS_LAST_LSB +: 4];
    // indices above 7 would name stages that do not exist
    if (last_stage > CSS_MAX_STAGE) begin
      last_stage = CSS_MAX_STAGE;
    end
    nstage = s.stage;
    next_s.avg_clear = !running || restart;
    if (!running) begin
      nstage = '0;
    end else if (avg_bus.done) begin
      next_s.stage_result_word[s.stage] = avg_bus.result;
      above = avg_bus.result > s.thr_hi;
      below = avg_bus.result < s.thr_lo;
      // a pressed pair cancels to midscale, so both flags fall clear
      if (s.diff_en[s.stage]) begin
        next_s.active_pos[s.stage] = above && !below;
        next_s.active_neg[s.stage] = below && !above;
      end else begin
        next_s.active_pos[s.stage] = above;
        next_s.active_neg[s.stage] = below;
      end
      if ({1'b0, s.stage} >= last_stage) begin
        // whole sequence is (last + 1) stage intervals
        nstage = '0;
        next_s.seq_cnt = 16'(s.seq_cnt + 16'h0001);
        next_s.seq_done = 1'b1;
      end else begin
        nstage = 3'(s.stage + 3'h1);
      end
    end
    next_s.stage = nstage;
    next_s.cur_cfg = next_s.stage_cfg[nstage];
    next_s.cur_cal = next_s.per_stage_calib_enable[nstage];
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.thr_lo <= CSS_THR_LO_RST;
      s.thr_hi <= CSS_THR_HI_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign sample_strobe_out = s.strobe;
  assign stage_out = s.stage;
  assign sensor_input_pin_setup_out = s.cur_cfg[CSS_CFG_MUX_LSB +: 16];
  assign positive_offset_code_out = s.cur_cfg[CSS_CFG_POS_LSB +: 6];
  assign negative_offset_code_out = s.cur_cfg[CSS_CFG_NEG_LSB +: 6];
  assign pos_offset_to_neg_input_out = s.cur_cfg[CSS_CFG_POS_SWAP];
  assign neg_offset_to_pos_input_out = s.cur_cfg[CSS_CFG_NEG_SWAP];
  assign calib_enable_out = s.cur_cal;
  assign sequence_done_out = s.seq_done;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
endmodule

// [sim/css_sequencer_monitor.sv]
module css_sequencer_monitor (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // sequencer
  input wire logic sample_strobe_out,
  input wire logic [2:0] stage_out,
  input wire logic sequence_done_out,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [7:0] gap;
  logic seen;
  // gap is only meaningful once a first strobe has been seen
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      gap <= 8'h00;
      seen <= 1'b0;
    end else if (sample_strobe_out) begin
      gap <= 8'h00;
      seen <= 1'b1;
    end else begin
      gap <= gap + 8'h01;
    end
  end
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_wait;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_strobe_period: assert property (
    sample_strobe_out && seen |-> gap == 8'h9f)
    else $error("modulator strobe spacing wrong");
  a_stage_order: assert property (
    $changed(stage_out) |->
    (stage_out == 3'h0 || stage_out == $past(stage_out) + 3'h1))
    else $error("stage stepped out of order");
  a_stage_after_strobe: assert property (
    $changed(stage_out) |->
    ($past(sample_strobe_out, 2) || $past(sample_strobe_out, 3)))
    else $error("stage moved without a final sample");
  a_restart_zero: assert property (
    sequence_done_out |-> stage_out == 3'h0)
    else $error("sequence did not restart at stage zero");
  a_done_single: assert property (
    sequence_done_out |=> !sequence_done_out [*8])
    else $error("sequence done pulse too long");
  a_write_answer: assert property (
    s_both_taken |=> s_resp_wait)
    else $error("write response timing wrong");
  a_read_answer: assert property (
    s_read_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response timing wrong");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

bind css_sequencer css_sequencer_monitor u_css_sequencer_monitor (
  .sys_clk_in, .srst_in, .sample_strobe_out, .stage_out, .sequence_done_out,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// [sim/css_sensor_model.sv]
module css_sensor_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // converter side
  input wire logic sample_strobe_in,
  input wire logic [2:0] stage_in,
  input wire logic [15:0] base_in,
  output logic [15:0] mod_sample_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up;
  // swing alternates per sample so only a true average recovers the level
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      up <= 1'b0;
    end else if (sample_strobe_in) begin
      up <= ~up;
    end
  end
  assign mod_sample_out = base_in + {5'h00, stage_in, 8'h00}
    + (up ? 16'h0040 : 16'hffc0);
endmodule

// [sim/css_sequencer_tb.sv]
module css_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import css_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] mod_sample_in, base = 16'h7f00, sensor_input_pin_setup_out;
  logic sample_strobe_out, sequence_done_out, calib_enable_out;
  logic pos_offset_to_neg_input_out, neg_offset_to_pos_input_out;
  logic [2:0] stage_out;
  logic [5:0] positive_offset_code_out, negative_offset_code_out;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, cfg0, cfg1, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, dec;
  int mismatches = 0, compares = 0, cyc = 0, n;
  int exp_q[$];

  css_sequencer u_css_sequencer (
    .sys_clk_in, .srst_in, .mod_sample_in, .sample_strobe_out, .stage_out,
    .sensor_input_pin_setup_out, .positive_offset_code_out,
    .negative_offset_code_out, .pos_offset_to_neg_input_out,
    .neg_offset_to_pos_input_out, .calib_enable_out, .sequence_done_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  css_sensor_model u_css_sensor_model (
    .sys_clk_in, .srst_in, .sample_strobe_in(sample_strobe_out),
    .stage_in(stage_out), .base_in(base), .mod_sample_out(mod_sample_in)
  );

  always #12.5 sys_clk_in = ~sys_clk_in;

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // shutdown hold plus two stages at decimation 64 take about 93000 cycles
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 99000) begin
      mismatches++;
      $display("MISMATCH %0t run timed out", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wchk(input logic [7:0] idx, input logic [31:0] d,
                      input logic [1:0] er);
    logic a;
    logic w;
    @(posedge sys_clk_in);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (a && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        a = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd_t(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk_in); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] ed,
                      input logic [1:0] er);
    rd_t(idx, rd, rs);
    chk(rd, ed);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  initial begin
    n = $urandom(32'h2043);
    base = 16'h7800 + 16'($urandom_range(0, 4095));
    cfg0 = $urandom;
    cfg1 = $urandom;
    dec = 2'($urandom_range(2, 3));
    repeat (20) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rchk(CSS_IDX_PWR, 32'h0, CSS_RESP_OKAY);
    rchk(CSS_IDX_THRESH, {CSS_THR_HI_RST, CSS_THR_LO_RST}, CSS_RESP_OKAY);
    rchk(8'h06, 32'h0, CSS_RESP_SLVERR);
    wchk(8'h06, 32'h1, CSS_RESP_SLVERR);
    wchk(CSS_IDX_RES0, 32'h1234, CSS_RESP_OKAY);
    wchk(CSS_IDX_CFG0, cfg0, CSS_RESP_OKAY);
    wchk(CSS_IDX_CFG0 + 8'h01, cfg1, CSS_RESP_OKAY);
    wchk(CSS_IDX_CALEN, 32'h3, CSS_RESP_OKAY);
    // low above high makes every result cross both limits at once
    wchk(CSS_IDX_THRESH, 32'h0000ffff, CSS_RESP_OKAY);
    wchk(CSS_IDX_DIFF, 32'h1, CSS_RESP_OKAY);
    rchk(CSS_IDX_CFG0, cfg0, CSS_RESP_OKAY);
    // shutdown must park stage 0 for longer than one stage interval
    wchk(CSS_IDX_PWR, {22'h0, dec, 4'h1, 4'h1}, CSS_RESP_OKAY);
    repeat (31200) @(posedge sys_clk_in);
    chk({29'h0, stage_out}, 32'h0);
    rchk(CSS_IDX_RES0, 32'h0, CSS_RESP_OKAY);
    rchk(CSS_IDX_STATUS, 32'h0, CSS_RESP_OKAY);
    wchk(CSS_IDX_PWR, {22'h0, dec, 4'h1, 4'h0}, CSS_RESP_OKAY);
    for (int s = 0; s < 2; s++) exp_q.push_back(int'(base) + s * 256);
    while (stage_out !== 3'h1) @(posedge sys_clk_in);
    chk({sensor_input_pin_setup_out, 1'b0, neg_offset_to_pos_input_out,
         negative_offset_code_out, 1'b0, pos_offset_to_neg_input_out,
         positive_offset_code_out}, cfg1 & 32'hffff7f7f);
    chk({31'h0, calib_enable_out}, 32'h1);
    n = 0;
    while (sequence_done_out !== 1'b1) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(32'(n), 32'(3 * 64 * CSS_TICK_CYCLES));
    chk({29'h0, stage_out}, 32'h0);
    chk({sensor_input_pin_setup_out, 1'b0, neg_offset_to_pos_input_out,
         negative_offset_code_out, 1'b0, pos_offset_to_neg_input_out,
         positive_offset_code_out}, cfg0 & 32'hffff7f7f);
    chk({31'h0, calib_enable_out}, 32'h1);
    for (int s = 0; s < 2; s++) begin
      rd_t(CSS_IDX_RES0 + 8'(s), rd, rs);
      chk(rd, 32'(exp_q.pop_front()));
    end
    rd_t(CSS_IDX_ACTIVE, rd, rs);
    chk(rd & 32'h00000303, 32'h00000202);
    rchk(CSS_IDX_STATUS, 32'h00010000, CSS_RESP_OKAY);
    finish_test();
  end
endmodule
